/* File: hdl/hdtt_tx.sv */
/*
  Host-to-device trigger transmitter: turns source edges into trigger
  packets on the low-speed upstream connection, waits for acknowledgment,
  resends on timeout and reports events.
  Assumes the packet port is taken as offered and ack_i is a one-cycle
  pulse on the same clock; the trigger pin is asynchronous.
*/
//
// Notes on behaviour
// - pulse format: both edges start, matching kind
// - rise-only format: rising edges only, rising packets
// - toggle format: rising edges, alternating packet kinds
// - packet inserted at next character boundary; here sent four characters after it, through the pipeline
// - delay value counts event-to-boundary in 1/24 bit
// - packets start only on character boundaries
// - four-character pipeline, six-character message
// - wait for acknowledgment; on time ends normally
// - timeout resends packet, restarts wait
// - resend limit reached ends transaction abnormally
// - no new transaction before current completes
// - timeout setting in microseconds, default twenty
// - resend limit setting, default three
// - zero timeout: finish right after sending
// - events for acknowledgment and for each resend
// - software sets and reads trigger level
// - no camera control disables the transmitter
// - runs only on master connection zero
`timescale 1ns/1ps
`include "hdtt_cfg.svh"
module hdtt_tx
	import hdtt_pkg::*;
#(
	parameter int unsigned CYC_PER_US = `HDTT_CYC_PER_US
)(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        trig_pin_i,
	input  wire logic        ack_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	output hdtt_pkt_t        pkt_o,
	output logic             ack_received_event_o,
	output logic             packet_resent_event_o,
	output logic             txn_abort_o
);
	hdtt_tx_state_t s;       // registered state
	hdtt_tx_state_t next_s;  // next state
	logic           pin_lvl; // synchronised pin level
	logic           tick;    // character boundary pulse
	logic           src_lvl; // selected trigger source level
	logic           rise;    // rising source edge
	logic           fall;    // falling source edge
	logic           enabled; // transmitter allowed to start
	logic           start;   // edge that opens a transaction
	logic           kind;    // packet kind for that edge, 1 = falling
	logic [7:0]     step;    // delay units per clock cycle

	// the wait counter holds 16-bit microseconds times this factor
	initial begin
		if (CYC_PER_US < 1 || CYC_PER_US > 255) begin
			$error("CYC_PER_US out of range");
		end
	end

	hdtt_edge_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (trig_pin_i),
		.lvl_o     (pin_lvl)
	);

	hdtt_char_timer u_char (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.fast_i    (s.fast),
		.tick_o    (tick)
	);

	// source selection, edge detection and format decode
	always_comb begin
		src_lvl = (s.src == HDTT_SRC_PIN) ? pin_lvl : s.sw_level;
		rise    = src_lvl & ~s.prev_lvl;
		fall    = ~src_lvl & s.prev_lvl;
		enabled = (s.src != HDTT_SRC_NONE) && (s.conn == 3'h0);
		step    = s.fast ? 8'(`HDTT_STEP_FAST) : 8'(`HDTT_STEP_SLOW);
		unique case (s.fmt)
			HDTT_RISE_ONLY_FORMAT: begin
				start = rise;
				kind  = 1'b0;
			end
			HDTT_TOGGLE_FORMAT: begin
				start = rise;
				kind  = s.toggle_fall;
			end
			default: begin
				start = rise | fall;
				kind  = fall;
			end
		endcase
	end

	// register port, transaction sequencing and event pulses
	always_comb begin
		next_s          = s;
		next_s.ack_ev   = 1'b0;
		next_s.rsnd_ev  = 1'b0;
		next_s.abort_ev = 1'b0;
		next_s.pkt.start = 1'b0;
		next_s.rdata    = '0;
		next_s.prev_lvl = src_lvl;
		// writes; format, source and connection take effect for the next transaction, speed and resend limit at once, timeout when the next wait is loaded
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`HDTT_REG_CTRL: begin
					next_s.fmt  = hdtt_fmt_t'(reg_wdata_i[`HDTT_CTRL_FMT_LSB +: 2]);
					next_s.fast = reg_wdata_i[`HDTT_CTRL_FAST_BIT];
					next_s.src  = hdtt_src_t'(reg_wdata_i[`HDTT_CTRL_SRC_LSB +: 2]);
					next_s.conn = reg_wdata_i[`HDTT_CTRL_CONN_LSB +: 3];
				end
				`HDTT_REG_TMO:   next_s.tmo_us   = reg_wdata_i[15:0];
				`HDTT_REG_RSND:  next_s.rsnd_lim = reg_wdata_i[7:0];
				`HDTT_REG_LEVEL: next_s.sw_level = reg_wdata_i[0];
				default: ;
			endcase
		end
		// reads answer one cycle later; unmapped reads return zero
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`HDTT_REG_CTRL: begin
					next_s.rdata[`HDTT_CTRL_FMT_LSB +: 2]  = s.fmt;
					next_s.rdata[`HDTT_CTRL_FAST_BIT]      = s.fast;
					next_s.rdata[`HDTT_CTRL_SRC_LSB +: 2]  = s.src;
					next_s.rdata[`HDTT_CTRL_CONN_LSB +: 3] = s.conn;
				end
				`HDTT_REG_TMO:   next_s.rdata[15:0] = s.tmo_us;
				`HDTT_REG_RSND:  next_s.rdata[7:0]  = s.rsnd_lim;
				`HDTT_REG_LEVEL: next_s.rdata[0]    = src_lvl;
				`HDTT_REG_STAT:  next_s.rdata[15:0] = {s.rsnd_cnt, 2'h0, src_lvl, s.last_abort,
					s.st, s.st != HDTT_IDLE};
				default: ;
			endcase
		end
		unique case (s.st)
			HDTT_IDLE: begin
				// edges are only looked at here, so busy-time edges vanish
				if (enabled && start) begin
					next_s.st       = HDTT_ALIGN;
					next_s.falling  = kind;
					next_s.delay    = '0;
					next_s.rsnd_cnt = '0;
					if (s.fmt == HDTT_TOGGLE_FORMAT) begin
						next_s.toggle_fall = ~s.toggle_fall;
					end
				end
			end
			HDTT_ALIGN: begin
				// measure event-to-boundary time for the camera
				if (tick) begin
					next_s.st    = HDTT_PIPE;
					next_s.chars = '0;
				end else if (s.delay <= 8'hff - step) begin
					next_s.delay = s.delay + step;
				end
			end
			HDTT_PIPE: begin
				// fixed pipeline keeps latency independent of the edge
				if (tick) begin
					if (s.chars == 3'(`HDTT_PIPE_CHARS - 1)) begin
						next_s.st          = HDTT_SEND;
						next_s.chars       = '0;
						next_s.pkt.start   = 1'b1;
						next_s.pkt.busy    = 1'b1;
						next_s.pkt.falling = s.falling;
						next_s.pkt.delay   = s.delay;
					end else begin
						next_s.chars = s.chars + 3'h1;
					end
				end
			end
			HDTT_SEND: begin
				if (tick) begin
					if (s.chars == 3'(`HDTT_MSG_CHARS - 1)) begin
						next_s.pkt.busy = 1'b0;
						if (s.tmo_us == 16'h0000) begin
							next_s.st = HDTT_IDLE;
						end else begin
							next_s.st       = HDTT_WAIT;
							next_s.wait_cnt = 24'(s.tmo_us * CYC_PER_US) - 24'h000001;
						end
					end else begin
						next_s.chars = s.chars + 3'h1;
					end
				end
			end
			HDTT_WAIT: begin
				if (ack_i) begin
					next_s.st         = HDTT_IDLE;
					next_s.ack_ev     = 1'b1;
					next_s.last_abort = 1'b0;
				end else if (s.wait_cnt == 24'h000000) begin
					if (s.rsnd_cnt < s.rsnd_lim) begin
						next_s.st       = HDTT_ALIGN;
						next_s.delay    = '0;
						next_s.rsnd_cnt = s.rsnd_cnt + 8'h01;
						next_s.rsnd_ev  = 1'b1;
					end else begin
						next_s.st         = HDTT_IDLE;
						next_s.abort_ev   = 1'b1;
						next_s.last_abort = 1'b1;
					end
				end else begin
					next_s.wait_cnt = s.wait_cnt - 24'h000001;
				end
			end
			default: next_s.st = HDTT_IDLE; // unused codes recover
		endcase
	end

	// synchronous reset; settings take their defaults
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s          <= '0;
			s.fmt      <= hdtt_fmt_t'(`HDTT_FMT_RST);
			s.fast     <= `HDTT_FAST_RST;
			s.src      <= hdtt_src_t'(`HDTT_SRC_RST);
			s.tmo_us   <= `HDTT_TMO_RST;
			s.rsnd_lim <= `HDTT_RSND_RST;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_o           = s.rdata;
	assign pkt_o                 = s.pkt;
	assign ack_received_event_o  = s.ack_ev;
	assign packet_resent_event_o = s.rsnd_ev;
	assign txn_abort_o           = s.abort_ev;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_resend;
		s.rsnd_ev && s.st == HDTT_ALIGN ##[1:130] s.st == HDTT_PIPE;
	endsequence

	property p_pulse_fall;
		(s.st == HDTT_IDLE && enabled && s.fmt == HDTT_PULSE_FORMAT && fall) |=> s.st == HDTT_ALIGN && s.falling;
	endproperty
	a_pulse_fall: assert property (p_pulse_fall) else $error("falling edge not sent");

	property p_rise_only;
		(s.st == HDTT_IDLE && s.fmt == HDTT_RISE_ONLY_FORMAT && fall) |=> s.st == HDTT_IDLE;
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("falling edge started a transaction");

	property p_toggle;
		(s.st == HDTT_IDLE && enabled && s.fmt == HDTT_TOGGLE_FORMAT && rise)
			|=> s.falling == $past(s.toggle_fall) && s.toggle_fall != $past(s.toggle_fall);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle kind did not alternate");

	property p_on_boundary;
		$rose(s.pkt.busy) |-> $past(tick) && s.pkt.start;
	endproperty
	a_on_boundary: assert property (p_on_boundary) else $error("packet off a boundary");

	property p_no_ack_check;
		(s.tmo_us == 16'h0000 && $fell(s.pkt.busy)) |-> s.st == HDTT_IDLE;
	endproperty
	a_no_ack_check: assert property (p_no_ack_check) else $error("waited with zero timeout");

	property p_ack_event;
		s.ack_ev |-> $past(s.st == HDTT_WAIT && ack_i) && s.st == HDTT_IDLE;
	endproperty
	a_ack_event: assert property (p_ack_event) else $error("ack event without ack");

	property p_resend;
		(s.st == HDTT_WAIT && s.wait_cnt == 24'h000000 && !ack_i && s.rsnd_cnt < s.rsnd_lim) |=> s_resend;
	endproperty
	a_resend: assert property (p_resend) else $error("timeout did not resend");

	property p_abort;
		s.abort_ev |-> $past(s.rsnd_cnt >= s.rsnd_lim) && s.st == HDTT_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("abort before resend limit");

	property p_hold_kind;
		(s.st != HDTT_IDLE && $past(s.st) != HDTT_IDLE) |-> $stable(s.falling);
	endproperty
	a_hold_kind: assert property (p_hold_kind) else $error("transaction changed mid-flight");

	property p_disabled;
		(s.st == HDTT_IDLE && !enabled) |=> s.st == HDTT_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled transmitter started");
endmodule

/* File: hdl/hdtt_cfg.svh */
/*
  Constants of the host-to-device trigger transmitter: register offsets,
  field positions, reset values and timing counts.
  Assumes a 250 MHz system clock; included by its bare name.
*/
`ifndef HDTT_CFG_SVH
`define HDTT_CFG_SVH

// clock and link timing, in ns
`define HDTT_CLK_NS          4
`define HDTT_CHAR_FAST_NS    240
`define HDTT_CHAR_SLOW_NS    480
`define HDTT_UNIT_FAST_NS    1
`define HDTT_UNIT_SLOW_NS    2
`define HDTT_US_NS           1000
// derived cycle counts (character times are whole multiples of the clock)
`define HDTT_CHAR_FAST_CYC   (`HDTT_CHAR_FAST_NS / `HDTT_CLK_NS)
`define HDTT_CHAR_SLOW_CYC   (`HDTT_CHAR_SLOW_NS / `HDTT_CLK_NS)
`define HDTT_CYC_PER_US      (`HDTT_US_NS / `HDTT_CLK_NS)
`define HDTT_STEP_FAST       (`HDTT_CLK_NS / `HDTT_UNIT_FAST_NS)
`define HDTT_STEP_SLOW       (`HDTT_CLK_NS / `HDTT_UNIT_SLOW_NS)
// pipeline and message length, in characters
`define HDTT_PIPE_CHARS      4
`define HDTT_MSG_CHARS       6

// register offsets
`define HDTT_REG_CTRL        8'h00
`define HDTT_REG_TMO         8'h04
`define HDTT_REG_RSND        8'h08
`define HDTT_REG_LEVEL       8'h0c
`define HDTT_REG_STAT        8'h10

// control field positions
`define HDTT_CTRL_FMT_LSB    0
`define HDTT_CTRL_FAST_BIT   2
`define HDTT_CTRL_SRC_LSB    3
`define HDTT_CTRL_CONN_LSB   5

// reset values
`define HDTT_FMT_RST         2'h0
`define HDTT_FAST_RST        1'h0
`define HDTT_SRC_RST         2'h1
`define HDTT_TMO_RST         16'h0014
`define HDTT_RSND_RST        8'h03

`endif

/* File: hdl/hdtt_pkg.sv */
/*
  Types of the host-to-device trigger transmitter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hdtt_pkg;

	// trigger packet format selection
	typedef enum logic [1:0] {
		HDTT_PULSE_FORMAT     = 2'h0,
		HDTT_RISE_ONLY_FORMAT = 2'h1,
		HDTT_TOGGLE_FORMAT    = 2'h2
	} hdtt_fmt_t;

	// trigger sourcing choice
	typedef enum logic [1:0] {
		HDTT_SRC_NONE = 2'h0,
		HDTT_SRC_SW   = 2'h1,
		HDTT_SRC_PIN  = 2'h2
	} hdtt_src_t;

	// transaction states, gray along idle-align-pipe-send-wait
	typedef enum logic [2:0] {
		HDTT_IDLE  = 3'h0,
		HDTT_ALIGN = 3'h1,
		HDTT_PIPE  = 3'h3,
		HDTT_SEND  = 3'h2,
		HDTT_WAIT  = 3'h6
	} hdtt_state_t;

	// packet insertion port
	typedef struct packed {
		logic       start;
		logic       busy;
		logic       falling;
		logic [7:0] delay;
	} hdtt_pkt_t;

	// character timer state
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} hdtt_ct_state_t;

	// pin synchroniser state
	typedef struct packed {
		logic [2:0] sh;
		logic       lvl;
	} hdtt_sync_state_t;

	// transmitter state
	typedef struct packed {
		hdtt_fmt_t   fmt;
		logic        fast;
		hdtt_src_t   src;
		logic [2:0]  conn;
		logic [15:0] tmo_us;
		logic [7:0]  rsnd_lim;
		logic        sw_level;
		logic        prev_lvl;
		hdtt_state_t st;
		logic        falling;
		logic        toggle_fall;
		logic [7:0]  delay;
		logic [2:0]  chars;
		logic [23:0] wait_cnt;
		logic [7:0]  rsnd_cnt;
		logic        ack_ev;
		logic        rsnd_ev;
		logic        abort_ev;
		logic        last_abort;
		hdtt_pkt_t   pkt;
		logic [31:0] rdata;
	} hdtt_tx_state_t;

endpackage

/* File: hdl/hdtt_edge_sync.sv */
/*
  Three-stage synchroniser for the trigger pin; the output follows once
  the second and third stages agree.
  Assumes an asynchronous input and one system clock.
*/
`timescale 1ns/1ps
module hdtt_edge_sync
	import hdtt_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      lvl_o
);
	hdtt_sync_state_t s;      // registered state
	hdtt_sync_state_t next_s; // next state

	// shift in; first stage is read only by the second
	always_comb begin
		next_s    = s;
		next_s.sh = {s.sh[1:0], pin_i};
		if (s.sh[1] == s.sh[2]) begin
			next_s.lvl = s.sh[2];
		end
	end

	// synchronous reset to low
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign lvl_o = s.lvl;

	property p_sync_agree;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$changed(s.lvl) |-> $past(s.sh[1] == s.sh[2]);
	endproperty
	a_sync_agree: assert property (p_sync_agree) else $error("level changed without agreement");
endmodule

/* File: hdl/hdtt_char_timer.sv */
/*
  Character boundary generator for the low-speed upstream connection.
  Assumes the system clock divides both character times exactly.
*/
`timescale 1ns/1ps
`include "hdtt_cfg.svh"
module hdtt_char_timer
	import hdtt_pkg::*;
#(
	parameter int unsigned FAST_CYC = `HDTT_CHAR_FAST_CYC,
	parameter int unsigned SLOW_CYC = `HDTT_CHAR_SLOW_CYC
)(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic fast_i,
	output logic      tick_o
);
	hdtt_ct_state_t s;      // registered state
	hdtt_ct_state_t next_s; // next state
	logic [7:0]     last;   // final count of a character

	// the counter is eight bits wide
	initial begin
		if (FAST_CYC < 9 || SLOW_CYC < 9 || FAST_CYC > 256 || SLOW_CYC > 256) begin
			$error("character period out of range");
		end
	end

	// wrap at the end of each character; a speed change applies to the character in progress
	always_comb begin
		last   = fast_i ? 8'(FAST_CYC - 1) : 8'(SLOW_CYC - 1);
		next_s = s;
		if (s.cnt >= last) begin
			next_s.cnt  = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt  = s.cnt + 8'h01;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

	property p_tick_gap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s.tick |=> !s.tick [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("character ticks too close");
endmodule

/* File: verif/hdtt_cam_model.sv */
/*
  Camera-side trigger receiver model: acknowledges every trigger packet
  a set number of cycles after the message ends, or stays silent.
  Assumes the transmitter's packet port and one shared system clock.
*/
`timescale 1ns/1ps
module hdtt_cam_model
	import hdtt_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire hdtt_pkt_t  pkt_i,
	input  wire logic       ack_en_i,   // low keeps the camera silent
	input  wire logic [7:0] ack_dly_i,  // ack comes this many cycles plus two after message end
	output logic            ack_o,
	output logic [7:0]      rx_delay_o  // delay value kept for compensation
);
	logic       was_busy;  // busy one cycle ago, finds message end
	logic [8:0] cnt;       // zero means no ack pending

	// ack timer: a slow camera is just a larger ack_dly_i
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			was_busy <= 1'b0;
			cnt <= 9'h000;
			ack_o <= 1'b0;
			rx_delay_o <= 8'h00;
		end else begin
			was_busy <= pkt_i.busy;
			ack_o <= 1'b0;
			if (pkt_i.start) begin
				rx_delay_o <= pkt_i.delay;
			end
			if (was_busy && !pkt_i.busy && ack_en_i) begin
				cnt <= {1'b0, ack_dly_i} + 9'h001;
			end else if (cnt != 9'h000) begin
				cnt <= cnt - 9'h001;
				ack_o <= (cnt == 9'h001);
			end
		end
	end
endmodule

/* File: verif/hdtt_tx_test.sv */
/*
  Self-checking bench of the trigger transmitter: register tasks, packet
  monitor and scenario sequence.
  Assumes the camera model beside it and CYC_PER_US set to 1.
*/
`timescale 1ns/1ps
module hdtt_tx_test;
	import hdtt_pkg::*;
	localparam int CH = 60;  // fast character time in cycles
	logic        sys_clk_i, rst_n_i, trig_pin_i, ack_i, reg_wr_i, reg_rd_i, ack_en;
	logic [7:0]  reg_addr_i, ack_dly, last_dly, cam_dly;
	logic [31:0] reg_wdata_i, reg_rdata_o, rv;
	hdtt_pkt_t   pkt_o;
	logic        ack_ev, rs_ev, ab_ev, last_fall;
	int          error_cnt, checks_done, cyc, t_wr, n_st, n_rs, n_ak, n_ab, blen;
	int          t_st[$];  // packet start times of the current test

	hdtt_tx #(.CYC_PER_US(1)) hdtt_tx_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.trig_pin_i(trig_pin_i), .ack_i(ack_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pkt_o(pkt_o),
		.ack_received_event_o(ack_ev), .packet_resent_event_o(rs_ev), .txn_abort_o(ab_ev));
	hdtt_cam_model hdtt_cam_model_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pkt_i(pkt_o),
		.ack_en_i(ack_en), .ack_dly_i(ack_dly), .ack_o(ack_i), .rx_delay_o(cam_dly));

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// monitor: one process owns cycle count and event tallies, so no race
	always @(posedge sys_clk_i) begin
		cyc++;
		if (reg_wr_i && reg_addr_i == 8'h0c) t_wr = cyc;
		if (pkt_o.start === 1'b1) begin
			n_st++;
			t_st.push_back(cyc);
			last_fall = pkt_o.falling;
			last_dly = pkt_o.delay;
			blen = 0;
		end
		if (pkt_o.busy === 1'b1) blen++;
		if (rs_ev === 1'b1) n_rs++;
		if (ack_ev === 1'b1) n_ak++;
		if (ab_ev === 1'b1) n_ab++;
	end

	task report_and_stop;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe: sample mid-cycle
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		d = reg_rdata_o;
	endtask

	// poll status until idle and not busy, bounded so a hang is reported
	task settle;
		int i;
		repeat (4) @(posedge sys_clk_i);
		for (i = 0; i < 3000; i++) begin
			rd(8'h10, rv);
			if (rv[3:0] === 4'h0) break;
		end
		if (i == 3000) chk(32'h0, 32'h1, "transaction never ended");
	endtask

	task expect_txn(input int ns, input int nr, input int na, input int nb, input logic f);
		chk(n_st, ns, "packet count");
		chk(n_rs, nr, "resend events");
		chk(n_ak, na, "ack events");
		chk(n_ab, nb, "abort events");
		if (ns > 0) chk(last_fall, f, "packet kind");
		n_st = 0;
		n_rs = 0;
		n_ak = 0;
		n_ab = 0;
		t_st.delete();
	endtask

	// watchdog well above the roughly 8k cycles the sequence needs
	initial begin
		#200_000;
		error_cnt++;
		report_and_stop;
	end

	initial begin
		rst_n_i = 1'b0;
		trig_pin_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		ack_en = 1'b1;
		ack_dly = 8'h03;
		{error_cnt, checks_done, cyc, t_wr, n_st, n_rs, n_ak, n_ab, blen} = '0;
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(8'h04, rv); chk(rv, 32'h14, "timeout default");
		rd(8'h08, rv); chk(rv, 32'h3, "resend default");
		rd(8'h00, rv); chk(rv, 32'h08, "control default");
		wr(8'h20, 32'hff);
		rd(8'h20, rv); chk(rv, 32'h0, "unmapped read");
		wr(8'h00, 32'h0c);  // pulse, fast, software source
		wr(8'h0c, 32'h1);
		rd(8'h0c, rv); chk(rv, 32'h1, "level readback");
		settle;
		rv = t_st[0] - t_wr - last_dly / 4;
		chk(rv >= 240 && rv <= 246, 1'b1, "edge to packet latency");
		chk(last_dly[1:0], 2'h0, "fast delay step");
		chk(cam_dly, last_dly, "camera delay value");
		chk(blen, 6 * CH, "fast message length");
		expect_txn(1, 0, 1, 0, 1'b0);
		wr(8'h0c, 32'h0);
		repeat (20) @(posedge sys_clk_i);
		wr(8'h0c, 32'h1);  // edge inside the transaction
		settle;
		expect_txn(1, 0, 1, 0, 1'b1);
		ack_dly <= 8'h0f;  // slower camera, still inside the timeout
		wr(8'h00, 32'h0d);
		wr(8'h0c, 32'h0);
		settle;
		expect_txn(0, 0, 0, 0, 1'b0);
		wr(8'h0c, 32'h1);
		settle;
		expect_txn(1, 0, 1, 0, 1'b0);
		ack_en <= 1'b0;
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0e);
		for (int i = 0; i < 4; i++) begin
			wr(8'h0c, 32'h0);
			settle;
			wr(8'h0c, 32'h1);
			settle;
			expect_txn(1, 0, 0, 0, i[0]);
		end
		wr(8'h00, 32'h02);
		wr(8'h0c, 32'h0);
		wr(8'h0c, 32'h1);
		settle;
		wr(8'h00, 32'h2e);
		wr(8'h0c, 32'h0);
		wr(8'h0c, 32'h1);
		settle;
		expect_txn(0, 0, 0, 0, 1'b0);
		wr(8'h04, 32'd20);
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h0c);
		wr(8'h0c, 32'h0);
		settle;
		chk((t_st[1] - t_st[0]) % CH, 0, "resend off boundary");
		chk((t_st[2] - t_st[1]) % CH, 0, "resend off boundary");
		chk(rv[4], 1'b1, "abnormal end flag");
		expect_txn(3, 2, 0, 1, 1'b1);
		ack_en <= 1'b1;
		wr(8'h00, 32'h10);  // pulse, slow, pin source
		@(posedge sys_clk_i);
		trig_pin_i <= 1'b1;
		settle;
		chk(rv[4], 1'b0, "normal end flag");
		chk(blen, 12 * CH, "slow message length");
		chk(last_dly[0], 1'b0, "slow delay step");
		expect_txn(1, 0, 1, 0, 1'b0);
		report_and_stop;
	end
endmodule
